// ### cbt_pkg.sv
// package of constants and types for the can bit timing block
package cbt_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_TIMING  = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_PRESC   = 8'h0C;

  // timing field positions (ADDR_TIMING)
  localparam int PROP_LSB  = 0;
  localparam int PH1_LSB   = 4;
  localparam int PH2_LSB   = 8;
  localparam int SJW_LSB   = 12;
  localparam int SEG_W     = 4;
  localparam int SJW_W     = 2;

  // control bits
  localparam int CTRL_ENA  = 0;
  localparam int CTRL_TXEN = 1;
  localparam int CTRL_TXB  = 2;

  // reset values
  localparam logic [31:0] TIMING_RST = 32'h0000_1333;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [7:0]  PRESC_RST  = 8'h01;

  // timing figures in quanta
  localparam logic [3:0] SYNC_TQ = 4'h1;
  localparam logic [3:0] IPT_TQ  = 4'h2;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef enum logic [2:0] {
    SEG_IDLE,
    SEG_SYNC,
    SEG_PROP,
    SEG_PH1,
    SEG_PH2
  } cbt_seg_t;

  typedef struct packed {
    logic [1:0] sjw;
    logic [3:0] ph2;
    logic [3:0] ph1;
    logic [3:0] prop;
  } cbt_timing_t;

  typedef struct packed {
    logic       bit_val;
    logic       sample_stb;
    logic       bit_start;
  } cbt_bit_t;

endpackage

// ### cbt_tq_gen.sv
// time quantum enable generator from the system clock
`timescale 1ns/10ps
module cbt_tq_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // prescaler control
  input  wire logic       run,
  input  wire logic [7:0] presc,
  // quantum tick
  output logic            tq_tick
);

  logic [7:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else if (!run || tq_tick) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // zero prescaler treated as one so quanta never stop
  assign tq_tick = run && ((presc <= 8'h01) || (cnt_reg == presc - 8'h01));

endmodule

// ### cbt_bit_timing.sv
// can bit timing and resynchronization with ahb-lite registers
// Behaviour
// R01: the transmit level is driven at the first quantum of the sync segment.
// R02: a differing bit edge is expected inside the sync segment.
// R03: a propagation segment follows sync to absorb bus and transceiver delay.
// R04: phase segment 1 may be lengthened when resynchronizing.
// R05: the bus is sampled as the bit value at the end of phase segment 1.
// R06: phase segment 2 shortening keeps it at least the processing time and at most phase 1.
// R07: processing time is 2 quanta so phase segment 2 is never below 2 quanta; the code caps phase 2 at phase 1 when phase 1 is shorter.
// R08: a late falling edge lengthens phase segment 1.
// R09: an early falling edge shortens phase segment 2.
// R10: any one correction is limited to the jump width.
// R11: software keeps the jump width no larger than phase segment 2.
// R12: early sampling leaves more phase 2 quanta for a larger jump width.
// R13: late sampling gives the propagation segment more quanta.
// R14: a bit is four segments of whole quanta.
// R15: hard sync on start-of-frame falling edge, resync on every falling edge; the code resyncs only on the first falling edge of each bit.
// R16: sync lasts one quantum and the phase error is measured against it.
`timescale 1ns/10ps
module cbt_bit_timing (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // can link
  input  wire logic        can_rx,
  output logic             can_tx,
  // bit stream to protocol logic
  input  wire logic        frame_busy,
  output cbt_pkg::cbt_bit_t bit_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic                 wr_pend_reg;
  logic [7:0]           wr_addr_reg;
  cbt_pkg::cbt_timing_t timing_reg;
  logic [2:0]           ctrl_reg;
  logic [7:0]           presc_reg;
  logic                 tq_tick;
  cbt_pkg::cbt_seg_t    seg_reg;
  logic [4:0]           qcnt_reg;
  logic [4:0]           ph1_len_reg;
  logic [4:0]           ph2_len_reg;
  logic                 rx_prev_reg;
  logic                 sampled_reg;
  logic                 tx_reg;
  logic                 edge_seen_reg;
  logic [7:0]           sync_cnt_reg;
  cbt_pkg::cbt_bit_t    bit_reg;
  logic                 rx_fall;
  logic                 seg_end;
  logic                 addr_ok;
  logic [4:0]           ph1_add_reg;
  logic [4:0]           jump_w;
  logic [4:0]           late_err;
  logic [4:0]           late_jump;
  logic                 early_jump;

  function automatic logic [4:0] ext(input logic [3:0] v);
    ext = {1'b0, v};
  endfunction

  function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
    min5 = (a < b) ? a : b;
  endfunction

  // ahb address phase
  assign addr_ok   = hsel && hready && (htrans == cbt_pkg::HTRANS_NONSEQ || htrans == cbt_pkg::HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timing_reg <= cbt_pkg::TIMING_RST[13:0];
      ctrl_reg   <= cbt_pkg::CTRL_RST[2:0];
      presc_reg  <= cbt_pkg::PRESC_RST;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        cbt_pkg::ADDR_TIMING: begin
          timing_reg <= hwdata[13:0];
        end
        cbt_pkg::ADDR_CTRL: begin
          ctrl_reg <= hwdata[2:0];
        end
        cbt_pkg::ADDR_PRESC: begin
          presc_reg <= hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data registered in the data phase; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        cbt_pkg::ADDR_TIMING: hrdata <= {18'h00000, timing_reg};
        cbt_pkg::ADDR_CTRL:   hrdata <= {29'h00000000, ctrl_reg};
        cbt_pkg::ADDR_STATUS: hrdata <= {16'h0000, sync_cnt_reg, 1'b0, seg_reg, edge_seen_reg, tx_reg,
                                         sampled_reg, 1'b0};
        cbt_pkg::ADDR_PRESC:  hrdata <= {24'h000000, presc_reg};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  cbt_tq_gen u_tq (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (ctrl_reg[cbt_pkg::CTRL_ENA]),
    .presc   (presc_reg),
    .tq_tick (tq_tick)
  );

  assign rx_fall = rx_prev_reg && !can_rx;
  assign seg_end = tq_tick && (qcnt_reg <= 5'h01);
  assign jump_w  = ext({2'b00, timing_reg.sjw}) + 5'h01;

  // R16 phase error counted in quanta after the sync quantum
  assign late_err   = (seg_reg == cbt_pkg::SEG_PROP) ? ext(timing_reg.prop) - qcnt_reg + 5'h01
                      : ext(timing_reg.prop) + ph1_len_reg - qcnt_reg + 5'h01;
  assign late_jump  = (tq_tick && rx_fall && !edge_seen_reg
                       && (seg_reg == cbt_pkg::SEG_PROP || seg_reg == cbt_pkg::SEG_PH1)) ? min5(late_err, jump_w)
                      : 5'h00;
  // early edge close to the bit end becomes the new sync quantum
  assign early_jump = tq_tick && rx_fall && !edge_seen_reg && seg_reg == cbt_pkg::SEG_PH2
                      && (ph2_len_reg - qcnt_reg + 5'h01) >= ext(cbt_pkg::IPT_TQ) && qcnt_reg <= jump_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_reg <= 1'b1;
    end else if (tq_tick) begin
      rx_prev_reg <= can_rx;
    end
  end

  // segment sequencer; edge seen once per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_reg       <= cbt_pkg::SEG_IDLE;
      qcnt_reg      <= 5'h00;
      ph1_len_reg   <= 5'h00;
      ph2_len_reg   <= 5'h00;
      edge_seen_reg <= 1'b0;
      ph1_add_reg   <= 5'h00;
    end else if (!ctrl_reg[cbt_pkg::CTRL_ENA]) begin
      seg_reg       <= cbt_pkg::SEG_IDLE;
      edge_seen_reg <= 1'b0;
      ph1_add_reg   <= 5'h00;
    end else if (tq_tick) begin
      case (seg_reg)
        cbt_pkg::SEG_IDLE: begin
          // R15 hard sync on sof
          if (rx_fall && !frame_busy) begin
            seg_reg       <= cbt_pkg::SEG_PROP;
            qcnt_reg      <= ext(timing_reg.prop);
            edge_seen_reg <= 1'b1;
          end
        end
        cbt_pkg::SEG_SYNC: begin
          // R16 sync lasts one quantum
          // R02 edge here is in phase
          seg_reg       <= cbt_pkg::SEG_PROP;
          qcnt_reg      <= ext(timing_reg.prop);
          edge_seen_reg <= rx_fall;
        end
        cbt_pkg::SEG_PROP: begin
          // R08 late edge here lengthens the coming phase 1
          if (rx_fall && !edge_seen_reg) begin
            edge_seen_reg <= 1'b1;
          end
          if (qcnt_reg <= 5'h01) begin
            // R03 propagation then phase 1
            // R14 four segments of quanta
            seg_reg     <= cbt_pkg::SEG_PH1;
            qcnt_reg    <= ext(timing_reg.ph1) + ph1_add_reg + late_jump;
            ph1_len_reg <= ext(timing_reg.ph1);
            ph1_add_reg <= 5'h00;
          end else begin
            qcnt_reg    <= qcnt_reg - 5'h01;
            ph1_add_reg <= ph1_add_reg + late_jump;
          end
        end
        cbt_pkg::SEG_PH1: begin
          // R08 late edge lengthens phase 1
          // R04 phase 1 extension
          // R10 bounded by jump width
          if (late_jump != 5'h00) begin
            edge_seen_reg <= 1'b1;
            qcnt_reg      <= qcnt_reg - 5'h01 + late_jump;
          end else if (qcnt_reg <= 5'h01) begin
            begin
              seg_reg     <= cbt_pkg::SEG_PH2;
              // R07 phase 2 never below processing time unless phase 1 is shorter
              // R06 never above phase 1
              ph2_len_reg <= min5((ext(timing_reg.ph2) < ext(cbt_pkg::IPT_TQ)) ? ext(cbt_pkg::IPT_TQ)
                                  : ext(timing_reg.ph2), ext(timing_reg.ph1));
              qcnt_reg    <= min5((ext(timing_reg.ph2) < ext(cbt_pkg::IPT_TQ)) ? ext(cbt_pkg::IPT_TQ)
                                  : ext(timing_reg.ph2), ext(timing_reg.ph1));
            end
          end else begin
            qcnt_reg <= qcnt_reg - 5'h01;
          end
        end
        cbt_pkg::SEG_PH2: begin
          // R09 early edge shortens phase 2
          // R10 bounded by jump width
          if (rx_fall && !edge_seen_reg && (ph2_len_reg - qcnt_reg + 5'h01) >= ext(cbt_pkg::IPT_TQ)) begin
            if (qcnt_reg <= ext({2'b00, timing_reg.sjw}) + 5'h01) begin
              seg_reg       <= cbt_pkg::SEG_PROP;
              qcnt_reg      <= ext(timing_reg.prop);
              edge_seen_reg <= 1'b1;
            end else begin
              qcnt_reg      <= qcnt_reg - ext({2'b00, timing_reg.sjw}) - 5'h01;
              edge_seen_reg <= 1'b1;
            end
          end else if (qcnt_reg <= 5'h01) begin
            seg_reg  <= cbt_pkg::SEG_SYNC;
            qcnt_reg <= ext(cbt_pkg::SYNC_TQ);
          end else begin
            qcnt_reg <= qcnt_reg - 5'h01;
          end
        end
        default: begin
          seg_reg <= cbt_pkg::SEG_IDLE;
        end
      endcase
    end
  end

  // R05 sample at end of phase 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled_reg <= 1'b1;
      bit_reg     <= '0;
    end else begin
      bit_reg.sample_stb <= 1'b0;
      bit_reg.bit_start  <= 1'b0;
      if (tq_tick && seg_reg == cbt_pkg::SEG_PH1 && qcnt_reg <= 5'h01 && !(rx_fall && !edge_seen_reg)) begin
        sampled_reg        <= can_rx;
        bit_reg.bit_val    <= can_rx;
        bit_reg.sample_stb <= 1'b1;
      end
      if ((tq_tick && seg_reg == cbt_pkg::SEG_SYNC) || early_jump) begin
        bit_reg.bit_start <= 1'b1;
      end
    end
  end

  // R01 drive bit at start of sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= 1'b1;
    end else if (!ctrl_reg[cbt_pkg::CTRL_TXEN]) begin
      tx_reg <= 1'b1;
    end else if (tq_tick && seg_reg == cbt_pkg::SEG_PH2 && qcnt_reg <= 5'h01) begin
      tx_reg <= ctrl_reg[cbt_pkg::CTRL_TXB];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cnt_reg <= 8'h00;
    end else if (tq_tick && rx_fall && seg_reg != cbt_pkg::SEG_SYNC) begin
      sync_cnt_reg <= sync_cnt_reg + 8'h01;
    end
  end

  assign can_tx  = tx_reg;
  assign bit_out = bit_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_tx_idle_recessive: assert property (@(posedge clk) disable iff (!rst_n) // R01
    !ctrl_reg[cbt_pkg::CTRL_TXEN] |=> can_tx) else $error("tx not recessive when disabled");
  a_tx_changes_sync: assert property (@(posedge clk) disable iff (!rst_n) // R01
    ctrl_reg[cbt_pkg::CTRL_TXEN] && $changed(can_tx) |-> seg_reg == cbt_pkg::SEG_SYNC)
    else $error("tx changed outside sync start");
  a_sync_one_tq: assert property (@(posedge clk) disable iff (!rst_n) // R16
    tq_tick && seg_reg == cbt_pkg::SEG_SYNC && ctrl_reg[cbt_pkg::CTRL_ENA] && !wr_pend_reg
    |=> seg_reg == cbt_pkg::SEG_PROP)
    else $error("sync segment longer than one quantum");
  a_sample_value: assert property (@(posedge clk) disable iff (!rst_n) // R05
    bit_reg.sample_stb |-> bit_reg.bit_val == $past(can_rx)) else $error("sampled value mismatch");
  a_sample_in_ph2: assert property (@(posedge clk) disable iff (!rst_n) // R05
    bit_reg.sample_stb && ctrl_reg[cbt_pkg::CTRL_ENA] |-> seg_reg == cbt_pkg::SEG_PH2)
    else $error("sample not at phase 1 end");
  a_ph2_min_ipt: assert property (@(posedge clk) disable iff (!rst_n) // R07
    seg_reg == cbt_pkg::SEG_PH2 |-> ph2_len_reg >= ext(cbt_pkg::IPT_TQ)) else $error("phase 2 below processing time");
  a_ph2_le_ph1: assert property (@(posedge clk) disable iff (!rst_n) // R06
    seg_reg == cbt_pkg::SEG_PH2 && timing_reg.ph1 >= cbt_pkg::IPT_TQ |-> ph2_len_reg <= ext(timing_reg.ph1))
    else $error("phase 2 longer than phase 1");
  a_ph1_jump_limit: assert property (@(posedge clk) disable iff (!rst_n) // R10
    seg_reg == cbt_pkg::SEG_PH1 |-> qcnt_reg <= ph1_len_reg + ext({2'b00, timing_reg.sjw}) + 5'h01)
    else $error("phase 1 extended beyond jump width");
  a_hard_sync: assert property (@(posedge clk) disable iff (!rst_n) // R15
    tq_tick && seg_reg == cbt_pkg::SEG_IDLE && rx_fall && !frame_busy && ctrl_reg[cbt_pkg::CTRL_ENA]
    |=> seg_reg == cbt_pkg::SEG_PROP) else $error("no hard sync on sof edge");

  c_hard_sync: cover property (@(posedge clk) seg_reg == cbt_pkg::SEG_IDLE ##1 seg_reg == cbt_pkg::SEG_PROP);
  c_ph2_short: cover property (@(posedge clk) tq_tick && seg_reg == cbt_pkg::SEG_PH2 && rx_fall && !edge_seen_reg);
  c_ph1_long: cover property (@(posedge clk) tq_tick && seg_reg == cbt_pkg::SEG_PH1 && rx_fall && !edge_seen_reg);
  c_sample: cover property (@(posedge clk) bit_reg.sample_stb);

endmodule

// ### cbt_node_model.sv
// behavioural model of a remote can node sending one frame
`timescale 1ns/10ps
module cbt_node_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // frame request
  input  wire logic        go,
  input  wire logic        alt,
  input  wire logic [15:0] bit_clks,
  input  wire logic [7:0]  nbits,
  // open-drain drive, 0 dominant
  output logic             drv
);
  logic [15:0] cnt;
  logic [7:0]  idx;
  logic        busy;
  ////////////////////////////////////////
  // frame opens with a dominant start bit
  // level changes only at own bit boundaries
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      drv  <= 1'b1;
      cnt  <= 16'h0;
      idx  <= 8'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      drv  <= 1'b0;
      cnt  <= 16'h0;
      idx  <= 8'h0;
    end else if (busy && cnt == bit_clks - 16'h1) begin
      cnt <= 16'h0;
      idx <= idx + 8'h1;
      // released bus floats recessive through the bus pull-up
      if (idx + 8'h1 == nbits) begin
        busy <= 1'b0;
        drv  <= 1'b1;
      end else begin
        drv <= alt ? ~drv : 1'b1;
      end
    end else if (busy) begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule

// ### tb_top.sv
// self-checking bench for the can bit timing block
`timescale 1ns/10ps
module tb_top;
  logic              clk, rst_n, hsel, hwrite, frame_busy, can_rx, can_tx;
  logic              hreadyout, hresp, p_go, p_alt, p_drv, prev_tx, prev_bs;
  logic [31:0]       haddr, hwdata, hrdata, rd, lfsr;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [15:0]       p_clks;
  logic [7:0]        p_nbits;
  cbt_pkg::cbt_bit_t bit_out;
  int                err_count, comparisons, per, nom;
  longint            t0;
  // wired-and bus, recessive when nobody pulls low
  assign can_rx = can_tx & p_drv;
  cbt_bit_timing dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .can_rx(can_rx), .can_tx(can_tx), .frame_busy(frame_busy), .bit_out(bit_out));
  cbt_node_model node (.clk(clk), .rst_n(rst_n), .go(p_go), .alt(p_alt), .bit_clks(p_clks), .nbits(p_nbits),
    .drv(p_drv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int nom_clks(int pr, int p1, int p2, int ps);
    int e;
    e = (p2 < 2) ? 2 : p2;
    if (e > p1) e = p1;
    return (1 + pr + p1 + e) * ((ps < 2) ? 1 : ps);
  endfunction
  // bounded wait, which: 0 bit start, 1 sample strobe, 2 hreadyout
  task automatic wait_on(int which);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!((which == 0 && bit_out.bit_start === 1'b1) || (which == 1 && bit_out.sample_stb === 1'b1)
      || (which == 2 && hreadyout === 1'b1)) && k < 2000);
    if (k >= 2000) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic ahb(logic wr, logic [31:0] a, logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= cbt_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_on(2);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(2);
    rd = hrdata;
  endtask
  task automatic cfg(int pr, int p1, int p2, int sj, int ps, int ctl);
    ahb(1'b1, cbt_pkg::ADDR_CTRL, 32'h0);
    ahb(1'b1, cbt_pkg::ADDR_TIMING, 32'(sj * 4096 + p2 * 256 + p1 * 16 + pr));
    ahb(1'b1, cbt_pkg::ADDR_PRESC, 32'(ps));
    ahb(1'b1, cbt_pkg::ADDR_CTRL, 32'(ctl));
    p_go <= 1'b1;
    @(posedge clk);
    p_go <= 1'b0;
    wait_on(1);
    frame_busy <= 1'b1;
    check("sof_val", bit_out.bit_val, 0);
  endtask
  task automatic frame(int alt, int nbits, int jmp);
    int lo, hi;
    lo = nom;
    hi = nom;
    wait_on(0);
    t0 = $time;
    for (int k = 1; k < nbits; k++) begin
      wait_on(1);
      check("bit_val", bit_out.bit_val, (alt != 0 && k < p_nbits) ? k % 2 : 1);
      wait_on(0);
      per = int'(($time - t0) / 20);
      t0 = $time;
      if (alt == 0) check("period", per, nom);
      else check("jump_bound", per >= nom - jmp && per <= nom + jmp, 1);
      if (per < lo) lo = per;
      if (per > hi) hi = per;
    end
    if (p_clks > nom) check("lengthen", hi > nom, 1);
    if (p_clks < nom) check("shorten", lo < nom, 1);
    frame_busy <= 1'b0;
  endtask
  ////////////////////////////////////////
  // drive level changes only at the sync segment
  // bit start pulse shows one cycle after a tx change seen here (one-clock quanta)
  always @(posedge clk) begin
    if (prev_bs) check("tx_align", bit_out.bit_start, 1);
    prev_bs <= rst_n && (can_tx !== prev_tx);
    prev_tx <= can_tx;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, frame_busy, p_go, p_alt, rst_n} = '0;
    {prev_tx, prev_bs, hsize, p_clks, p_nbits} = {2'b10, 3'h2, 16'd12, 8'd1};
    {err_count, comparisons, lfsr} = {32'd0, 32'd0, 32'h59B0_7E13};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, cbt_pkg::ADDR_TIMING, 32'h0);
    check("timing_rst", rd, cbt_pkg::TIMING_RST);
    ahb(1'b0, cbt_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_rst", rd, cbt_pkg::CTRL_RST);
    ahb(1'b0, cbt_pkg::ADDR_PRESC, 32'h0);
    check("presc_rst", rd[7:0], cbt_pkg::PRESC_RST);
    ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    check("unmapped", rd, 32'h0);
    check("hresp", hresp, 0);
    // sample point spread early to late over the timings
    // corner clamps first, then random timings with idle bus after the start bit
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      if (i == 0) {per, nom} = {32'h0104_0100, 32'd1};
      else if (i == 1) {per, nom} = {32'h0304_0900, 32'd2};
      else {per, nom} = {8'(1 + lfsr[2:0]), 8'(2 + lfsr[5:3]), 8'(lfsr[9:6]), 8'h0, 32'(lfsr[11:10])};
      p_nbits <= 8'd1;
      p_alt <= 1'b0;
      // remote start bit lasts one nominal bit so the sample point sees it
      p_clks <= 16'(nom_clks(per[31:24], per[23:16], per[15:8], nom));
      cfg(per[31:24], per[23:16], per[15:8], 0, nom, 1);
      nom = nom_clks(per[31:24], per[23:16], per[15:8], nom);
      frame(0, 4, 0);
    end
    // fast then slow remote node, jump width two quanta
    for (int d = -1; d <= 1; d += 2) begin
      nom = nom_clks(2, 5, 4, 1);
      p_clks <= 16'(nom + d);
      p_nbits <= 8'd12;
      p_alt <= 1'b1;
      // jump width kept within phase 2
      cfg(2, 5, 4, 1, 1, 1);
      frame(1, 14, 2);
    end
    // own transmit level, recessive then dominant then recessive
    p_nbits <= 8'd1;
    p_alt <= 1'b0;
    cfg(2, 5, 4, 1, 1, 7);
    for (int v = 0; v < 2; v++) begin
      ahb(1'b1, cbt_pkg::ADDR_CTRL, 32'(3 + 4 * v));
      wait_on(0);
      wait_on(1);
      check("tx_level", can_tx, v);
      check("tx_sample", bit_out.bit_val, v);
    end
    frame_busy <= 1'b0;
    conclude();
  end
endmodule
